// File: core/mit_prescale.sv
// Prescaler clock enable generator selecting system, system/4 or sub clock
`timescale 1ns/100ps
module mit_prescale (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Control
  input wire logic [1:0] prescale_src_sel,
  input wire logic sub_clk_tick,
  // Prescaled clock enable
  output logic prescaled_clock
);
  logic [1:0] div_reg;

  // Free-running divide by four of the system clock
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end

  // Source choice: 00 sys, 01 sys/4, 1x sub clock
  always_comb begin
    if (prescale_src_sel == mit_pkg::PSC_SYS) begin
      prescaled_clock = 1'b1;
    end else if (prescale_src_sel == mit_pkg::PSC_SYS4) begin
      prescaled_clock = (div_reg == mit_pkg::SYS_DIV4_TOP);
    end else begin
      prescaled_clock = sub_clk_tick;
    end
  end
endmodule

// File: core/mit_tick.sv
// One time base divider: overflow pulse every 2^(8+sel) prescaled ticks
`timescale 1ns/100ps
module mit_tick (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Control
  input wire logic run,
  input wire logic [2:0] period_sel,
  input wire logic prescaled_clock,
  // Overflow pulse
  output logic overflow
);
  logic [14:0] cnt_reg;
  logic [15:0] wide;
  logic [14:0] mask;

  // Mask of the counter bits in use for the chosen period
  always_comb begin
    wide = 16'h0001 << (mit_pkg::TB_BASE_EXP + int'(period_sel));
    mask = wide[14:0] - 15'h0001;
    if (period_sel == 3'h7) begin
      mask = 15'h7FFF;
    end
  end

  // Counter runs only while enabled, cleared while stopped
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 15'h0000;
    end else if (!run) begin
      cnt_reg <= 15'h0000;
    end else if (prescaled_clock) begin
      cnt_reg <= (cnt_reg + 15'h0001) & mask;
    end
  end

  assign overflow = run && prescaled_clock && ((cnt_reg & mask) == mask);
endmodule

// File: core/mit_top.sv
// Interrupt request, vectoring, wake-up and time base top with AXI4-Lite
`timescale 1ns/100ps
module mit_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // AXI4-Lite write address and data
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Peripheral events and sub clock tick
  input wire mit_pkg::mit_events_type events,
  input wire logic sub_clk_tick,
  // Processor core sequencer
  input wire mit_pkg::mit_core_type core,
  output logic vec_req_reg,
  output logic [2:0] vec_num_reg,
  output logic wake_reg
);
  logic [1:0] psc_reg;
  logic [7:0] tb0_reg;
  logic [7:0] tb1_reg;
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic [7:0] flag_dly_reg;
  logic [7:0] en_reg;
  logic global_int_en;
  logic prescaled_clock;
  logic [1:0] tick_ovf;
  logic [7:0] set_vec;
  logic [7:0] svc_clr;
  logic [7:0] sw_clr;
  logic [7:0] pend;
  logic any_pend;
  logic [2:0] vec_pick;
  logic [7:0] aw_addr_reg;
  logic aw_have_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_have_reg;
  logic wr_go;
  logic wr_hit;
  logic [31:0] rd_mux;
  logic rd_hit;

  // Prescaler and the two time base dividers
  mit_prescale u_psc (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .prescale_src_sel(psc_reg),
    .sub_clk_tick(sub_clk_tick),
    .prescaled_clock(prescaled_clock)
  );

  mit_tick u_tick0 (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(tb0_reg[mit_pkg::TB_RUN_BIT]),
    .period_sel(tb0_reg[mit_pkg::TB_SEL_W-1:0]),
    .prescaled_clock(prescaled_clock),
    .overflow(tick_ovf[0])
  );

  mit_tick u_tick1 (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .run(tb1_reg[mit_pkg::TB_RUN_BIT]),
    .period_sel(tb1_reg[mit_pkg::TB_SEL_W-1:0]),
    .prescaled_clock(prescaled_clock),
    .overflow(tick_ovf[1])
  );

  // AXI write channel capture: address and data in either order
  assign wr_go = aw_have_reg && w_have_reg && !s_axi_bvalid;

  // Registered address ready: low while a captured address waits
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
    end else if (wr_go) begin
      s_axi_awready <= 1'b1;
    end else begin
      s_axi_awready <= !aw_have_reg;
    end
  end

  // Registered data ready: low while captured data waits
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_wready <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
    end else if (wr_go) begin
      s_axi_wready <= 1'b1;
    end else begin
      s_axi_wready <= !w_have_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= mit_pkg::RST_BYTE;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_have_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_go) begin
      aw_have_reg <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      w_have_reg <= 1'b0;
      w_data_reg <= mit_pkg::RD_ZERO;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_have_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_go) begin
      w_have_reg <= 1'b0;
    end
  end

  // Address decode of a write
  always_comb begin
    case (aw_addr_reg)
      mit_pkg::ADDR_PSC, mit_pkg::ADDR_TB0, mit_pkg::ADDR_TB1,
      mit_pkg::ADDR_FLAG, mit_pkg::ADDR_EN, mit_pkg::ADDR_CORE: begin
        wr_hit = 1'b1;
      end
      default: begin
        wr_hit = 1'b0;
      end
    endcase
  end

  // Write response, SLVERR on unmapped address
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mit_pkg::RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? mit_pkg::RESP_OKAY : mit_pkg::RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Configuration registers, byte lane 0 only
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      psc_reg <= 2'h0;
      tb0_reg <= mit_pkg::RST_BYTE;
      tb1_reg <= mit_pkg::RST_BYTE;
      en_reg <= mit_pkg::RST_BYTE;
    end else if (wr_go && w_strb_reg[0]) begin
      case (aw_addr_reg)
        mit_pkg::ADDR_PSC: psc_reg <= w_data_reg[mit_pkg::PSC_SEL_W-1:0];
        mit_pkg::ADDR_TB0: tb0_reg <= w_data_reg[7:0] & 8'h87;
        mit_pkg::ADDR_TB1: tb1_reg <= w_data_reg[7:0] & 8'h87;
        mit_pkg::ADDR_EN: en_reg <= w_data_reg[7:0];
        default: en_reg <= en_reg;
      endcase
    end
  end

  // Software clear of flags: write one to clear at the flag address
  always_comb begin
    sw_clr = 8'h00;
    if (wr_go && w_strb_reg[0] && aw_addr_reg == mit_pkg::ADDR_FLAG) begin
      sw_clr = w_data_reg[7:0];
    end
  end

  // Hardware event sources
  always_comb begin
    set_vec = 8'h00;
    set_vec[mit_pkg::F_MEMW] = events.mem_write_done;
    set_vec[mit_pkg::F_LVOLT] = events.low_volt_detect;
    set_vec[mit_pkg::F_TICK0] = tick_ovf[0];
    set_vec[mit_pkg::F_TICK1] = tick_ovf[1];
    set_vec[mit_pkg::F_SERIAL] = events.serial_if_event;
    set_vec[mit_pkg::F_UART0] = events.uart_event[0];
    set_vec[mit_pkg::F_UART1] = events.uart_event[1];
    // Group flag set by any enabled member request
    set_vec[mit_pkg::F_GROUP] =
      (flag_reg[mit_pkg::F_MEMW] && en_reg[mit_pkg::F_MEMW]) ||
      (flag_reg[mit_pkg::F_LVOLT] && en_reg[mit_pkg::F_LVOLT]);
  end

  // Pending requests gated by enables and stack state
  always_comb begin
    pend = flag_reg & en_reg;
    pend[mit_pkg::F_MEMW] = 1'b0;
    pend[mit_pkg::F_LVOLT] = 1'b0;
    pend[mit_pkg::F_GROUP] = flag_reg[mit_pkg::F_GROUP] &&
      en_reg[mit_pkg::E_GROUP];
    any_pend = global_int_en && !core.stack_full && (pend != 8'h00);
  end

  // Fixed priority: group, tick0, tick1, serial, uart0, uart1
  always_comb begin
    if (pend[mit_pkg::F_GROUP]) begin
      vec_pick = mit_pkg::VEC_GROUP;
    end else if (pend[mit_pkg::F_TICK0]) begin
      vec_pick = mit_pkg::VEC_TICK0;
    end else if (pend[mit_pkg::F_TICK1]) begin
      vec_pick = mit_pkg::VEC_TICK1;
    end else if (pend[mit_pkg::F_SERIAL]) begin
      vec_pick = mit_pkg::VEC_SERIAL;
    end else if (pend[mit_pkg::F_UART0]) begin
      vec_pick = mit_pkg::VEC_UART0;
    end else begin
      vec_pick = mit_pkg::VEC_UART1;
    end
  end

  // Service-time clear of the flag whose vector is taken
  always_comb begin
    svc_clr = 8'h00;
    if (core.vec_take && vec_req_reg) begin
      case (vec_num_reg)
        mit_pkg::VEC_GROUP: svc_clr[mit_pkg::F_GROUP] = 1'b1;
        mit_pkg::VEC_TICK0: svc_clr[mit_pkg::F_TICK0] = 1'b1;
        mit_pkg::VEC_TICK1: svc_clr[mit_pkg::F_TICK1] = 1'b1;
        mit_pkg::VEC_SERIAL: svc_clr[mit_pkg::F_SERIAL] = 1'b1;
        mit_pkg::VEC_UART0: svc_clr[mit_pkg::F_UART0] = 1'b1;
        mit_pkg::VEC_UART1: svc_clr[mit_pkg::F_UART1] = 1'b1;
        default: svc_clr = 8'h00;
      endcase
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins
  assign flag_next = (flag_reg & ~(svc_clr | sw_clr)) | set_vec;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flag_reg <= mit_pkg::RST_BYTE;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Global enable: cleared on service entry, set by return-from-isr
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      global_int_en <= 1'b0;
    end else if (core.vec_take && vec_req_reg) begin
      global_int_en <= 1'b0;
    end else if (core.return_from_isr_op) begin
      global_int_en <= 1'b1;
    end else if (wr_go && w_strb_reg[0] &&
                 aw_addr_reg == mit_pkg::ADDR_CORE) begin
      global_int_en <= w_data_reg[mit_pkg::GIE_BIT];
    end
  end

  // Vector request to the core; the core pushes only the PC
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      vec_req_reg <= 1'b0;
      vec_num_reg <= mit_pkg::VEC_GROUP;
    end else if (core.vec_take && vec_req_reg) begin
      vec_req_reg <= 1'b0;
    end else begin
      vec_req_reg <= any_pend;
      vec_num_reg <= vec_pick;
    end
  end

  // Wake-up on any flag rising edge, enables ignored
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flag_dly_reg <= mit_pkg::RST_BYTE;
      wake_reg <= 1'b0;
    end else begin
      flag_dly_reg <= flag_reg;
      wake_reg <= (flag_reg & ~flag_dly_reg) != 8'h00;
    end
  end

  // Read mux, unused bits read zero
  always_comb begin
    rd_mux = mit_pkg::RD_ZERO;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      mit_pkg::ADDR_PSC: rd_mux[1:0] = psc_reg;
      mit_pkg::ADDR_TB0: rd_mux[7:0] = tb0_reg;
      mit_pkg::ADDR_TB1: rd_mux[7:0] = tb1_reg;
      mit_pkg::ADDR_FLAG: rd_mux[7:0] = flag_reg;
      mit_pkg::ADDR_EN: rd_mux[7:0] = en_reg;
      mit_pkg::ADDR_CORE: begin
        rd_mux[mit_pkg::GIE_BIT] = global_int_en;
        rd_mux[mit_pkg::WAKE_BIT] = wake_reg;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Registered read ready: low from address capture until data taken
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_arready <= 1'b1;
    end else begin
      s_axi_arready <= !s_axi_rvalid;
    end
  end

  // Read channel: one cycle after address acceptance

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= mit_pkg::RD_ZERO;
      s_axi_rresp <= mit_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? mit_pkg::RESP_OKAY : mit_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// File: dv/mit_assertions.sv
// Checker: bus handshake and vectoring properties at the top ports
`timescale 1ns/100ps
module mit_checker (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core side
  input wire mit_pkg::mit_core_type core,
  input wire logic vec_req_reg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  property p_full_block;
    $rose(vec_req_reg) |-> !$past(core.stack_full);
  endproperty
  a_full_block: assert property (p_full_block)
    else $error("vector raised while stack full");
  property p_svc_drop;
    vec_req_reg && core.vec_take |=> !vec_req_reg [*2];
  endproperty
  a_svc_drop: assert property (p_svc_drop)
    else $error("request stayed after service");
  property p_rd_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_answer: assert property (p_rd_answer)
    else $error("read not answered");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data not held");
  property p_ar_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_refuse: assert property (p_ar_refuse)
    else $error("address taken while data pending");
  property p_wr_answer;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_wr_answer: assert property (p_wr_answer)
    else $error("write not answered");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_upper_zero;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("upper read bits not zero");
endmodule
bind mit_top mit_checker u_chk (
  .ref_clk, .nrst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .core, .vec_req_reg
);

// File: dv/mit_core_model.sv
// Core sequencer model: takes vectors, runs a short service, returns
`timescale 1ns/100ps
module mit_core_model (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Bench controls
  input wire logic slow,
  input wire logic use_return_from_isr_op,
  input wire logic stack_full,
  // Block side
  input wire logic vec_req_reg,
  output mit_pkg::mit_core_type core
);
  logic [3:0] wait_reg;
  logic [3:0] isr_reg;
  // Take after an optional stall, serve eight cycles, then return
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wait_reg <= 4'h0;
      isr_reg <= 4'h0;
      core <= '0;
    end else begin
      core.stack_full <= stack_full;
      core.vec_take <= 1'b0;
      core.return_from_isr_op <= 1'b0;
      if (isr_reg != 4'h0) begin
        isr_reg <= isr_reg - 4'h1;
        core.return_from_isr_op <= (isr_reg == 4'h1) && use_return_from_isr_op;
      end else if (vec_req_reg && !core.vec_take && !core.stack_full) begin
        wait_reg <= wait_reg + 4'h1;
        if (!slow || wait_reg == 4'h3) begin
          core.vec_take <= 1'b1;
          wait_reg <= 4'h0;
          isr_reg <= 4'h8;
        end
      end
    end
  end
endmodule

// File: dv/mit_top_tb_top.sv
// Testbench: registers, time base periods, vectoring and wake-up
`timescale 1ns/100ps
`define CHK(nm, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    error_cnt++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
  end \
end
module mit_top_tb_top;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  mit_pkg::mit_events_type events = '0;
  logic sub_clk_tick = 1'b0;
  mit_pkg::mit_core_type core;
  logic vec_req_reg;
  logic [2:0] vec_num_reg;
  logic wake_reg;
  logic slow = 1'b0;
  logic use_return_from_isr_op = 1'b0;
  logic stack_full = 1'b1;
  int error_cnt = 0;
  int compares = 0;
  int cyc = 0;
  int tw;
  int t0;
  int per;
  logic seen;
  logic [1:0] resp;
  logic [31:0] rdat;
  logic [2:0] vn;
  logic [7:0] ta;
  // Source, unit and period code of each time base run
  int tab [5] = '{32'h00, 32'h10, 32'h20, 32'h09, 32'h0F};
  mit_top DUT (
    .ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .events, .sub_clk_tick, .core,
    .vec_req_reg, .vec_num_reg, .wake_reg
  );
  mit_core_model u_core (
    .ref_clk, .nrst, .slow, .use_return_from_isr_op, .stack_full, .vec_req_reg, .core
  );
  always #5 ref_clk = ~ref_clk;
  // Cycle count, sub clock tick every fourth cycle, hang cut-off
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    sub_clk_tick <= (cyc[1:0] == 2'h3);
    if (cyc == 95000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    logic aw_hit;
    logic w_hit;
    logic bv;
    logic done;
    n = 0;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done && n < 40) begin
      @(negedge ref_clk);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      done = s_axi_bvalid && s_axi_bready;
      resp = s_axi_bresp;
      bv = s_axi_bvalid;
      @(posedge ref_clk);
      if (aw_hit) s_axi_awvalid <= 1'b0;
      if (w_hit) s_axi_wvalid <= 1'b0;
      s_axi_bready <= bv && !done;
      n++;
    end
    @(posedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    logic ar_hit;
    logic done;
    n = 0;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done && n < 40) begin
      @(negedge ref_clk);
      ar_hit = s_axi_arvalid && s_axi_arready;
      done = s_axi_rvalid && s_axi_rready;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge ref_clk);
      if (ar_hit) s_axi_arvalid <= 1'b0;
      s_axi_rready <= !s_axi_arvalid && !done;
      n++;
    end
    @(posedge ref_clk);
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e,
                    input string nm);
    rd(a);
    `CHK(nm, e, rdat[7:0]);
  endtask
  task automatic ww(input int lim);
    int n;
    n = 0;
    seen = 1'b0;
    while (!seen && n < lim) begin
      @(negedge ref_clk);
      seen = wake_reg;
      tw = cyc;
      n++;
    end
    @(posedge ref_clk);
  endtask
  task automatic wt();
    int n;
    logic got;
    n = 0;
    got = 1'b0;
    while (!got && n < 2000) begin
      @(negedge ref_clk);
      got = core.vec_take && vec_req_reg;
      vn = vec_num_reg;
      n++;
    end
    @(posedge ref_clk);
  endtask
  task automatic pulse(input logic [4:0] ev);
    events <= ev;
    @(posedge ref_clk);
    events <= '0;
    ww(6);
  endtask
  task automatic complete_run();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 6; i++) begin
      rc(8'(4 * i), 8'h00, "reset");
    end
    wr(mit_pkg::ADDR_PSC, 32'hFF);
    rc(mit_pkg::ADDR_PSC, 8'h03, "psc");
    wr(mit_pkg::ADDR_TB0, 32'h7F);
    rc(mit_pkg::ADDR_TB0, 8'h07, "tb0");
    wr(mit_pkg::ADDR_TB1, 32'h78);
    rc(mit_pkg::ADDR_TB1, 8'h00, "tb1");
    wr(mit_pkg::ADDR_TB0, 32'h0);
    wr(8'h40, 32'h1);
    `CHK("wr resp", mit_pkg::RESP_SLVERR, resp);
    rd(8'h40);
    `CHK("rd resp", mit_pkg::RESP_SLVERR, resp);
    // Every peripheral event source at once, no time base tick, while the stack is full
    wr(mit_pkg::ADDR_EN, 32'hFF);
    pulse(5'h1F);
    `CHK("wake", 1'b1, seen);
    rc(mit_pkg::ADDR_FLAG, 8'hF3, "flags");
    wr(mit_pkg::ADDR_CORE, 32'h1);
    repeat (8) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("held", 1'b0, vec_req_reg);
    @(posedge ref_clk);
    stack_full <= 1'b0;
    wt();
    `CHK("vector", mit_pkg::VEC_GROUP, vn);
    repeat (12) @(posedge ref_clk);
    rd(mit_pkg::ADDR_CORE);
    `CHK("plain return", 1'b0, rdat[0]);
    rc(mit_pkg::ADDR_FLAG, 8'hF3, "kept");
    wr(mit_pkg::ADDR_FLAG, 32'h83);
    rc(mit_pkg::ADDR_FLAG, 8'hF0, "group");
    wr(mit_pkg::ADDR_FLAG, 32'h80);
    use_return_from_isr_op <= 1'b1;
    slow <= 1'b1;
    wr(mit_pkg::ADDR_CORE, 32'h1);
    for (int i = 3; i < 6; i++) begin
      wt();
      `CHK("vector", 3'(i), vn);
    end
    repeat (12) @(posedge ref_clk);
    rc(mit_pkg::ADDR_FLAG, 8'h00, "served");
    rd(mit_pkg::ADDR_CORE);
    `CHK("return_from_isr_op", 1'b1, rdat[0]);
    // Time base vector, then periods with the global enable off
    use_return_from_isr_op <= 1'b0;
    wr(mit_pkg::ADDR_PSC, 32'h0);
    wr(mit_pkg::ADDR_TB0, 32'h80);
    wt();
    `CHK("tick0", mit_pkg::VEC_TICK0, vn);
    wr(mit_pkg::ADDR_TB0, 32'h0);
    rc(mit_pkg::ADDR_FLAG, 8'h00, "tick");
    rd(mit_pkg::ADDR_CORE);
    `CHK("tick global", 1'b0, rdat[0]);
    for (int i = 0; i < 5; i++) begin
      ta = mit_pkg::ADDR_TB0 + 8'(tab[i][3] * 4);
      per = (1 << (8 + tab[i][2:0])) * ((tab[i] >> 4) == 0 ? 1 : 4);
      wr(mit_pkg::ADDR_PSC, 32'(tab[i] >> 4));
      wr(ta, 32'h80 | 32'(tab[i] & 7));
      ww(70000);
      t0 = tw;
      wr(mit_pkg::ADDR_FLAG, 32'hFF);
      ww(70000);
      `CHK("period", per, tw - t0);
      wr(ta, 32'h0);
      wr(mit_pkg::ADDR_FLAG, 32'hFF);
    end
    wr(mit_pkg::ADDR_FLAG, 32'hFF);
    ww(400);
    `CHK("stopped", 1'b0, seen);
    pulse(5'h04);
    `CHK("wake", 1'b1, seen);
    pulse(5'h04);
    `CHK("preset", 1'b0, seen);
    complete_run();
  end
endmodule

// File: inc/mit_pkg.sv
// Package: register map, field layout and types of the interrupt block
package mit_pkg;
  // AXI4-Lite byte addresses
  localparam logic [7:0] ADDR_PSC = 8'h00;
  localparam logic [7:0] ADDR_TB0 = 8'h04;
  localparam logic [7:0] ADDR_TB1 = 8'h08;
  localparam logic [7:0] ADDR_FLAG = 8'h0C;
  localparam logic [7:0] ADDR_EN = 8'h10;
  localparam logic [7:0] ADDR_CORE = 8'h14;
  // Field positions
  localparam int TB_RUN_BIT = 7;
  localparam int TB_SEL_W = 3;
  localparam int PSC_SEL_W = 2;
  localparam int GIE_BIT = 0;
  localparam int WAKE_BIT = 1;
  // Request flag bit positions in the flag and enable registers
  localparam int F_MEMW = 0;
  localparam int F_LVOLT = 1;
  localparam int F_TICK0 = 2;
  localparam int F_TICK1 = 3;
  localparam int F_SERIAL = 4;
  localparam int F_UART0 = 5;
  localparam int F_UART1 = 6;
  localparam int F_GROUP = 7;
  localparam int NFLAG = 8;
  // Enable register bit of the multi-function group enable
  localparam int E_GROUP = 7;
  // Divider: 2^8 is the shortest period, 2^15 the longest
  localparam int TB_BASE_EXP = 8;
  localparam int TB_CNT_W = 15;
  localparam logic [1:0] SYS_DIV4_TOP = 2'h3;
  // Prescaler source codes
  localparam logic [1:0] PSC_SYS = 2'h0;
  localparam logic [1:0] PSC_SYS4 = 2'h1;
  // Reset values and bus response codes
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Vector numbers presented to the core
  localparam logic [2:0] VEC_GROUP = 3'h0;
  localparam logic [2:0] VEC_TICK0 = 3'h1;
  localparam logic [2:0] VEC_TICK1 = 3'h2;
  localparam logic [2:0] VEC_SERIAL = 3'h3;
  localparam logic [2:0] VEC_UART0 = 3'h4;
  localparam logic [2:0] VEC_UART1 = 3'h5;

  // Peripheral event pulses
  typedef struct packed {
    logic mem_write_done;
    logic low_volt_detect;
    logic serial_if_event;
    logic [1:0] uart_event;
  } mit_events_type;

  // Core sequencer handshake
  typedef struct packed {
    logic vec_take;
    logic return_from_isr_op;
    logic stack_full;
  } mit_core_type;
endpackage
